/* File: design/rpc_parity_checker.sv */
// Parity checker of a registered address/command buffer, with standby handling.
// Assumes inputs synchronous to ref_clk_i and a pull-up on the shared error line.
//
// How it works
// - Selected data plus the parity bit must sum even, else PARTIAL_PARITY_OUT goes high and the flag low.
// - The two configuration bits choose which data inputs enter the parity sum.
// - A flag pulled low stays low at least two cycles unless reset comes first.
// - Errors on consecutive cycles keep the flag low for as long as they persist.
// - Reset releases the flag and forces the partial-parity output low.
// - With both selects high and no check or error output pending, the block enters standby and its outputs keep their values.
// - Data sampled on the edge that starts standby is neither checked nor flagged.
// - Errors two to four edges before standby give a one-cycle PARTIAL_PARITY_OUT and a two-cycle flag.
// - An error one edge before standby holds both outputs through standby plus two cycles, or one cycle when only bit one is set.
// - Chip selects are active low and only both high suspend sampling.
// - The configuration bits pick 1:1, first-of-pair or second-of-pair operation.
`timescale 1ns/1ps
`include "rpc_consts.svh"

module rpc_parity_checker
  import rpc_pkg::*;
#(
  parameter int DATA_W   = `RPC_DATA_W,
  parameter int ERROR_FLAG_N_MIN = `RPC_ERROR_FLAG_N_MIN
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              cfg_bit_zero_i,
  input  wire logic              cfg_bit_one_i,
  input  wire logic              primary_select_n_i,
  input  wire logic              secondary_select_n_i,
  input  wire logic [DATA_W-1:0] data_inputs_i,
  input  wire logic              parity_bit_in_i,
  output logic                   partial_parity_out_o,
  output logic                   error_flag_n_o,
  output logic                   error_flag_oe_o
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  if (DATA_W != 25) begin : g_bad_width
    $error("DATA_W must be 25 to match the coverage masks.");
  end
  if ((ERROR_FLAG_N_MIN < 1) || (ERROR_FLAG_N_MIN > 3)) begin : g_bad_min
    $error("ERROR_FLAG_N_MIN must lie between 1 and 3.");
  end

  localparam logic [`RPC_CNT_W-1:0] MIN_LOAD  = `RPC_CNT_W'(ERROR_FLAG_N_MIN - 1);
  localparam logic [`RPC_CNT_W-1:0] TAIL_STD  = `RPC_CNT_W'(`RPC_TAIL_STD - 1);
  localparam logic [`RPC_CNT_W-1:0] TAIL_REGA = `RPC_CNT_W'(`RPC_TAIL_REGA - 1);

  // --------------------------------------------------------------------------
  // Sampling pipeline
  // --------------------------------------------------------------------------
  logic low_power_state;
  logic sum_now;
  logic sum1, v1, sum2, v2, tag2, lpm_prev;
  logic next_sum1, next_v1, next_sum2, next_v2, next_tag2, next_lpm_prev;
  logic lpm_entry;
  logic chk_sum, chk_valid, chk_tag;
  logic err_now, err_tag;

  assign low_power_state = primary_select_n_i & secondary_select_n_i;
  assign lpm_entry = low_power_state & ~lpm_prev;

  rpc_parity_sum #(
    .DATA_W (DATA_W)
  ) u_sum (
    .data_i         (data_inputs_i),
    .cfg_bit_zero_i (cfg_bit_zero_i),
    .cfg_bit_one_i  (cfg_bit_one_i),
    .sum_o          (sum_now)
  );

  always_comb begin
    next_sum1     = sum_now;
    next_v1       = ~low_power_state;
    next_sum2     = sum1;
    next_v2       = v1;
    next_tag2     = lpm_entry;
    next_lpm_prev = low_power_state;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sum1     <= 1'b0;
      v1       <= 1'b0;
      sum2     <= 1'b0;
      v2       <= 1'b0;
      tag2     <= 1'b0;
      lpm_prev <= 1'b0;
    end else begin
      sum1     <= next_sum1;
      v1       <= next_v1;
      sum2     <= next_sum2;
      v2       <= next_v2;
      tag2     <= next_tag2;
      lpm_prev <= next_lpm_prev;
    end
  end

  // Parity meets its word one stage later when bit zero is set.
  always_comb begin
    if (cfg_bit_zero_i) begin
      chk_sum   = sum2;
      chk_valid = v2;
      chk_tag   = tag2;
    end else begin
      chk_sum   = sum1;
      chk_valid = v1;
      chk_tag   = lpm_entry;
    end
  end

  assign err_now = chk_valid & (chk_sum ^ parity_bit_in_i);
  assign err_tag = err_now & chk_tag & low_power_state;

  // --------------------------------------------------------------------------
  // Output state
  // --------------------------------------------------------------------------
  rpc_state_e              state, next_state;
  logic                    partial_parity_out, next_ppo;
  logic                    error_flag_n_n, next_error_flag_n_n;
  logic [`RPC_CNT_W-1:0]   cnt, next_cnt;
  logic                    busy;

  assign busy = v1 | v2 | partial_parity_out | ~error_flag_n_n;

  always_comb begin
    next_state  = state;
    next_ppo    = partial_parity_out;
    next_error_flag_n_n = error_flag_n_n;
    next_cnt    = cnt;
    case (state)
      RPC_RUN: begin
        if (err_now) begin
          next_ppo    = 1'b1;
          next_error_flag_n_n = 1'b0;
          next_cnt    = MIN_LOAD;
          if (err_tag) begin
            next_state = RPC_LPM_HOLD;
          end
        end else if (low_power_state && !busy) begin
          next_ppo    = partial_parity_out;
          next_error_flag_n_n = error_flag_n_n;
        end else begin
          next_ppo = 1'b0;
          if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
          end else begin
            next_error_flag_n_n = 1'b1;
          end
        end
      end
      RPC_LPM_HOLD: begin
        next_ppo    = 1'b1;
        next_error_flag_n_n = 1'b0;
        if (!low_power_state) begin
          next_state = RPC_TAIL;
          next_cnt   = (!cfg_bit_zero_i && cfg_bit_one_i) ? TAIL_REGA : TAIL_STD;
        end
      end
      RPC_TAIL: begin
        if (err_now) begin
          next_ppo    = 1'b1;
          next_error_flag_n_n = 1'b0;
          next_cnt    = MIN_LOAD;
          if (err_tag) begin
            next_state = RPC_LPM_HOLD;
          end else begin
            next_state = RPC_RUN;
          end
        end else if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else begin
          next_state  = RPC_RUN;
          next_ppo    = 1'b0;
          next_error_flag_n_n = 1'b1;
        end
      end
      default: begin
        next_state  = RPC_RUN;
        next_ppo    = `RPC_PPO_RST;
        next_error_flag_n_n = `RPC_ERROR_FLAG_N_N_RST;
        next_cnt    = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state  <= RPC_RUN;
      partial_parity_out    <= `RPC_PPO_RST;
      error_flag_n_n <= `RPC_ERROR_FLAG_N_N_RST;
      cnt    <= '0;
    end else begin
      state  <= next_state;
      partial_parity_out    <= next_ppo;
      error_flag_n_n <= next_error_flag_n_n;
      cnt    <= next_cnt;
    end
  end

  // --------------------------------------------------------------------------
  // Pins
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      partial_parity_out_o <= `RPC_PPO_RST;
      error_flag_n_o       <= `RPC_ERROR_FLAG_N_N_RST;
      error_flag_oe_o      <= 1'b0;
    end else begin
      partial_parity_out_o <= next_ppo;
      error_flag_n_o       <= next_error_flag_n_n;
      error_flag_oe_o      <= ~next_error_flag_n_n;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  parity_error_out_a: assert property ((state == RPC_RUN) && err_now |=>
    (partial_parity_out_o && !error_flag_n_o))
    else $error("Parity error did not reach the pins.");
  flag_min_low_a: assert property ($fell(error_flag_n_o) |=> !error_flag_n_o)
    else $error("Error flag released too early.");
  flag_persist_a: assert property (err_now [*2] |=> !error_flag_n_o [*2])
    else $error("Consecutive errors did not keep the flag low.");
  reset_state_a: assert property (@(posedge ref_clk_i) disable iff (1'b0)
    rst_i |=> (!partial_parity_out_o && error_flag_n_o && !error_flag_oe_o))
    else $error("Reset did not clear the outputs.");
  idle_hold_a: assert property ((state == RPC_RUN) && low_power_state && !busy && !err_now
    |=> ##1 $stable(partial_parity_out_o))
    else $error("Outputs moved in standby.");
  entry_ignored_a: assert property ((state == RPC_RUN) && low_power_state && !busy
    |=> ##1 (!partial_parity_out_o && error_flag_n_o))
    else $error("Data on a standby edge was taken.");
  ppo_single_a: assert property ((state == RPC_RUN) && err_now && !err_tag ##1 !err_now
    |=> !partial_parity_out_o)
    else $error("PARTIAL_PARITY_OUT pulse longer than one cycle.");
  standby_hold_a: assert property ((state == RPC_LPM_HOLD) && low_power_state
    |=> ##1 (partial_parity_out_o && !error_flag_n_o))
    else $error("Outputs dropped during standby hold.");
  drain_pair_a: assert property (error_flag_oe_o == !error_flag_n_o)
    else $error("Enable and flag level disagree.");

endmodule : rpc_parity_checker

/* File: design/rpc_parity_sum.sv */
// Even-parity sum over the data inputs covered in the configured mode.
// Assumes bit k of the data bus carries data input k+1.
`timescale 1ns/1ps

module rpc_parity_sum #(
  parameter int DATA_W = 25
) (
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic              cfg_bit_zero_i,
  input  wire logic              cfg_bit_one_i,
  output logic                   sum_o
);

  logic [DATA_W-1:0] covered;

  // --------------------------------------------------------------------------
  // Per-input coverage
  // --------------------------------------------------------------------------
  for (genvar k = 0; k < DATA_W; k++) begin : g_cov
    localparam int N = k + 1;
    localparam bit IN_STD = (N == 2) || (N == 3) || (N == 5) || (N == 6) || (N >= 8);
    localparam bit IN_REGA = IN_STD && (N <= 14);
    localparam bit IN_REGB = (N <= 6) || ((N >= 8) && (N <= 10)) || (N == 12) || (N == 13);
    always_comb begin
      if (cfg_bit_zero_i && cfg_bit_one_i) begin
        covered[k] = data_i[k] & IN_REGB;
      end else if (cfg_bit_one_i) begin
        covered[k] = data_i[k] & IN_REGA;
      end else begin
        covered[k] = data_i[k] & IN_STD;
      end
    end
  end

  assign sum_o = ^covered;

endmodule : rpc_parity_sum

/* File: inc/rpc_consts.svh */
// Constants of the registered parity checker with standby handling.
// Assumes inclusion by bare name from any file that needs them.
`ifndef RPC_CONSTS_SVH
`define RPC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define RPC_DATA_W        25
`define RPC_CNT_W         2

// ----------------------------------------------------------------------------
// Timing counts in clock cycles
// ----------------------------------------------------------------------------
`define RPC_ERROR_FLAG_N_MIN      2
`define RPC_TAIL_STD      2
`define RPC_TAIL_REGA     1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RPC_PPO_RST       1'b0
`define RPC_ERROR_FLAG_N_N_RST    1'b1

`endif

/* File: inc/rpc_pkg.sv */
// Types shared by the registered parity checker.
// Assumes nothing beyond a SystemVerilog compiler.
package rpc_pkg;

  // --------------------------------------------------------------------------
  // Output state
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RPC_RUN,
    RPC_LPM_HOLD,
    RPC_TAIL
  } rpc_state_e;

endpackage : rpc_pkg

/* File: testbench/registered_parity_checker_standby_bench.sv */
// Self-checking bench of the parity checker with a controller model.
// Assumes a 100 MHz clock and inputs driven at the falling edge.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_total++; \
  $display("[ERR] %s expected %b seen %b", nm, ex, got); end end

module registered_parity_checker_standby_bench
  import rpc_pkg::*;
;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cfg_bit_zero_i = 1'b0;
  logic        cfg_bit_one_i = 1'b0;
  logic [24:0] word = 25'h0;
  logic        bad = 1'b0;
  logic [1:0]  sel = 2'b00;
  logic [24:0] data;
  logic        par;
  logic        pri_n;
  logic        sec_n;
  logic        partial_parity_out_o;
  logic        error_flag_n_o;
  logic        error_flag_oe_o;
  logic [31:0] seed = 32'd94452;
  logic [31:0] r;
  logic [7:0]  hist;
  logic [1:0]  modes [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
  int          d;
  bit          chk;
  int          err_total = 0;
  int          comparisons = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  rpc_ctrl_model u_ctrl (.ref_clk_i(ref_clk_i), .cfg_bit_zero_i(cfg_bit_zero_i),
    .cfg_bit_one_i(cfg_bit_one_i), .word_i(word), .bad_i(bad), .sel_n_i(sel), .data_o(data),
    .parity_o(par), .primary_select_n_o(pri_n), .secondary_select_n_o(sec_n));

  rpc_parity_checker #(.DATA_W(25)) u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .cfg_bit_zero_i(cfg_bit_zero_i), .cfg_bit_one_i(cfg_bit_one_i),
    .primary_select_n_i(pri_n), .secondary_select_n_i(sec_n), .data_inputs_i(data),
    .parity_bit_in_i(par), .partial_parity_out_o(partial_parity_out_o),
    .error_flag_n_o(error_flag_n_o), .error_flag_oe_o(error_flag_oe_o));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic exp_flag_n(input logic [7:0] h, input int dd);
    return ~(h[dd-1] | h[dd]);
  endfunction : exp_flag_n

  // Checks the outputs due now, then presents the next word.
  task automatic step(input logic [24:0] w, input logic b, input logic [1:0] s);
    @(negedge ref_clk_i);
    if (chk) begin
      `CHK("ppo", hist[d-1], partial_parity_out_o)
      `CHK("flag_n", exp_flag_n(hist, d), error_flag_n_o)
    end
    `CHK("flag_oe", ~error_flag_n_o, error_flag_oe_o)
    word <= w;
    bad <= b;
    sel <= s;
    hist = {hist[6:0], b & ~&s};
  endtask : step

  task automatic results();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  // ------------------------------------------------------------
  // Main sequence, one pass per configuration
  // ------------------------------------------------------------
  initial begin
    for (int m = 0; m < 4; m++) begin
      chk = 0;
      rst_i <= 1'b1;
      {cfg_bit_one_i, cfg_bit_zero_i} <= modes[m];
      repeat (5) step(25'h0, 1'b0, 2'b00);
      `CHK("rst ppo", 1'b0, partial_parity_out_o)
      `CHK("rst flag_n", 1'b1, error_flag_n_o)
      rst_i <= 1'b0;
      hist = 8'h0;
      d = modes[m][0] ? 3 : 2;
      chk = 1;
      repeat (40) begin
        r = xs();
        step(r[24:0], r[31:30] == 2'b00, {r[27], r[26] & ~r[27]});
      end
      r = xs();
      step(r[24:0], 1'b1, 2'b00);
      step(~r[24:0], 1'b0, 2'b01);
      repeat (4) step(r[24:0], 1'b1, 2'b11);
      repeat (6) step(r[24:0], 1'b0, 2'b10);
      chk = 0;
      step(r[24:0], 1'b1, 2'b00);
      repeat (4) step(~r[24:0], 1'b0, 2'b11);
      `CHK("lpm ppo", 1'b1, partial_parity_out_o)
      `CHK("lpm flag_n", 1'b0, error_flag_n_o)
      step(r[24:0], 1'b0, 2'b11);
      `CHK("lpm hold", 1'b0, error_flag_n_o)
      repeat (3) step(r[24:0], 1'b0, 2'b00);
      `CHK("tail ppo", modes[m] != 2'b10, partial_parity_out_o)
      step(r[24:0], 1'b0, 2'b00);
      `CHK("tail flag_n", 1'b1, error_flag_n_o)
      repeat (4) step(r[24:0], 1'b0, 2'b00);
    end
    results();
  end
endmodule : registered_parity_checker_standby_bench

/* File: testbench/rpc_ctrl_model.sv */
// Controller model: presents words and selects, sends parity one or two cycles late.
// Assumes the bench updates its inputs by non-blocking assignment at the falling edge.
`timescale 1ns/1ps

module rpc_ctrl_model (
  input  wire logic        ref_clk_i,
  input  wire logic        cfg_bit_zero_i,
  input  wire logic        cfg_bit_one_i,
  input  wire logic [24:0] word_i,
  input  wire logic        bad_i,
  input  wire logic [1:0]  sel_n_i,
  output logic      [24:0] data_o,
  output logic             parity_o,
  output logic             primary_select_n_o,
  output logic             secondary_select_n_o
);
  logic [24:0] mask;
  logic        p1 = 1'b0;
  logic        p2 = 1'b0;

  assign mask = (cfg_bit_zero_i & cfg_bit_one_i) ? 25'h0001bbf :
                (!cfg_bit_zero_i & cfg_bit_one_i) ? 25'h0003fb6 : 25'h1ffffb6;
  // Deselected data lines show the inverse word, never a stale copy.
  assign data_o = (&sel_n_i) ? ~word_i : word_i;
  assign {primary_select_n_o, secondary_select_n_o} = sel_n_i;
  always @(negedge ref_clk_i) begin
    p1 <= ^(word_i & mask) ^ bad_i;
    p2 <= p1;
  end
  assign parity_o = cfg_bit_zero_i ? p2 : p1;
endmodule : rpc_ctrl_model
